// >>> core/drive_assy_pkg.sv
// Package holding assembly layouts, codes and modes for the drive channel block
package drive_assy_pkg;
   localparam logic [7:0] ASM_BASIC_OUT = 8'h14;
   localparam logic [7:0] ASM_EXT_OUT = 8'h15;
   localparam logic [7:0] ASM_BASIC_IN = 8'h46;
   localparam logic [7:0] ASM_EXT_IN = 8'h47;
   localparam logic [7:0] ASM_NATIVE_OUT = 8'h64;
   localparam logic [7:0] ASM_NATIVE_IN = 8'h65;
   // Output byte 0 bits
   localparam int B_RUN_FWD = 0;
   localparam int B_RUN_REV = 1;
   localparam int B_FAULT_RST = 2;
   localparam int B_NET_CTRL = 5;
   localparam int B_NET_REF = 6;
   // Input byte 0 bits
   localparam int B_FAULTED = 0;
   localparam int B_WARNING = 1;
   localparam int B_RUN_F = 2;
   localparam int B_RUN_R = 3;
   localparam int B_READY = 4;
   localparam int B_CTRL_NET = 5;
   localparam int B_REF_NET = 6;
   localparam int B_AT_REF = 7;
   // Internal control word switching bits
   localparam int CW_CMD_SW = 12;
   localparam int CW_REF_SW = 13;
   localparam logic [1:0] TIER_HIGHEST = 2'h2;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   typedef enum logic [0:0] {
      COMBINED_PROFILE = 1'b0,
      SPLIT_PROFILE = 1'b1
   } profile_e;
   typedef enum logic [1:0] {
      SRC_NETWORK = 2'b00,
      SRC_TERMINAL = 2'b01,
      SRC_ANALOG_TWO = 2'b10
   } source_e;
endpackage : drive_assy_pkg

// >>> core/drive_assy_if.sv
// Interface carrying cyclic assemblies between scanner and drive
`timescale 1ns/1ps
interface drive_assy_if;
   logic [7:0] out_asm_id;
   logic [31:0] out_data;
   logic out_valid;
   logic [7:0] in_asm_id;
   logic [31:0] in_data;
   logic in_valid;
   modport scanner (output out_asm_id, output out_data, output out_valid,
      output in_asm_id, input in_data, input in_valid);
   modport drive (input out_asm_id, input out_data, input out_valid,
      input in_asm_id, output in_data, output in_valid);
endinterface : drive_assy_if

// >>> core/scanner_end.sv
// Scanner end: packs user commands into the chosen output assembly
`timescale 1ns/1ps
module scanner_end (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   drive_assy_if.scanner link,
   // User side
   input wire logic [7:0] out_sel,
   input wire logic [7:0] in_sel,
   input wire logic send,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic fault_reset,
   input wire logic bus_control_request,
   input wire logic bus_reference_request,
   input wire logic [15:0] native_command_word,
   input wire logic [15:0] speed_reference_word,
   output logic [31:0] status_data,
   output logic status_valid
);
   typedef struct packed {
      logic [7:0] oid;
      logic [7:0] iid;
      logic [31:0] odat;
      logic ovld;
      logic [31:0] sdat;
      logic svld;
   } state_s;
   state_s st_r;
   state_s st_nxt;
   logic [7:0] b0;

   always_comb begin
      st_nxt = st_r;
      b0 = 8'h00;
      st_nxt.ovld = 1'b0;
      st_nxt.svld = link.in_valid;
      if (link.in_valid) begin
         st_nxt.sdat = link.in_data;
      end
      if (send) begin
         st_nxt.oid = out_sel;
         st_nxt.iid = in_sel;
         st_nxt.ovld = 1'b1;
         b0[drive_assy_pkg::B_RUN_FWD] = run_fwd;
         b0[drive_assy_pkg::B_FAULT_RST] = fault_reset;
         if (out_sel == drive_assy_pkg::ASM_EXT_OUT) begin
            b0[drive_assy_pkg::B_RUN_REV] = run_rev;
            b0[drive_assy_pkg::B_NET_CTRL] = bus_control_request;
            b0[drive_assy_pkg::B_NET_REF] = bus_reference_request;
         end
         if (out_sel == drive_assy_pkg::ASM_NATIVE_OUT) begin
            st_nxt.odat = {speed_reference_word, native_command_word};
         end else begin
            st_nxt.odat = {speed_reference_word, 8'h00, b0};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.out_asm_id = st_r.oid;
   assign link.out_data = st_r.odat;
   assign link.out_valid = st_r.ovld;
   assign link.in_asm_id = st_r.iid;
   assign status_data = st_r.sdat;
   assign status_valid = st_r.svld;
endmodule : scanner_end

// >>> core/drive_end.sv
// Drive end: unpacks assemblies, selects channels, packs status
`timescale 1ns/1ps
module drive_end (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   drive_assy_if.drive link,
   // Configuration
   input wire logic [1:0] access_level,
   input wire logic profile_set,
   input wire drive_assy_pkg::profile_e profile_select,
   input wire logic switch_enable,
   // Terminals
   input wire logic logic_input_three,
   input wire logic term_run_fwd,
   input wire logic term_run_rev,
   input wire logic [15:0] analog_input_two,
   // Drive core status
   input wire logic [15:0] native_status_word,
   input wire logic [15:0] output_speed_word,
   input wire logic [7:0] drive_state,
   input wire logic st_faulted,
   input wire logic st_warning,
   input wire logic st_run_fwd,
   input wire logic st_run_rev,
   input wire logic st_ready,
   input wire logic st_at_ref,
   // Drive core commands
   output logic [15:0] control_word,
   output logic [15:0] speed_setpoint_word,
   output logic run_fwd,
   output logic run_rev,
   output logic fault_reset,
   output logic standard_profile,
   output logic cmd_from_net,
   output logic ref_from_net,
   output drive_assy_pkg::profile_e profile_active
);
   typedef struct packed {
      drive_assy_pkg::profile_e prof;
      logic std;
      logic [15:0] ncmd;
      logic [15:0] nref;
      logic nfwd;
      logic nrev;
      logic nfrst;
      logic nctl;
      logic nrq;
      logic [15:0] cw;
      logic [15:0] sp;
      logic fwd;
      logic rev;
      logic frst;
      logic cnet;
      logic rnet;
      logic [31:0] idat;
      logic ivld;
   } state_s;
   state_s st_r;
   state_s st_nxt;
   logic [7:0] b0;
   logic top_tier;
   logic sel_cmd_net;
   logic sel_ref_net;

   always_comb begin
      st_nxt = st_r;
      b0 = link.out_data[7:0];
      top_tier = (access_level == drive_assy_pkg::TIER_HIGHEST);
      st_nxt.ivld = 1'b0;
      if (profile_set) begin
         st_nxt.prof = profile_select;
      end
      if (link.out_valid) begin
         st_nxt.std = (link.out_asm_id == drive_assy_pkg::ASM_BASIC_OUT) ||
            (link.out_asm_id == drive_assy_pkg::ASM_EXT_OUT);
         unique case (link.out_asm_id)
            drive_assy_pkg::ASM_BASIC_OUT: begin
               st_nxt.nfwd = b0[drive_assy_pkg::B_RUN_FWD];
               st_nxt.nfrst = b0[drive_assy_pkg::B_FAULT_RST];
               st_nxt.nrev = 1'b0;
               st_nxt.nctl = 1'b0;
               st_nxt.nrq = 1'b0;
               st_nxt.nref = link.out_data[31:16];
            end
            drive_assy_pkg::ASM_EXT_OUT: begin
               st_nxt.nfwd = b0[drive_assy_pkg::B_RUN_FWD];
               st_nxt.nrev = b0[drive_assy_pkg::B_RUN_REV];
               st_nxt.nfrst = b0[drive_assy_pkg::B_FAULT_RST];
               st_nxt.nctl = b0[drive_assy_pkg::B_NET_CTRL];
               st_nxt.nrq = b0[drive_assy_pkg::B_NET_REF];
               st_nxt.nref = link.out_data[31:16];
            end
            drive_assy_pkg::ASM_NATIVE_OUT: begin
               st_nxt.ncmd = link.out_data[15:0];
               st_nxt.nref = link.out_data[31:16];
            end
            default: begin
               st_nxt.std = st_r.std;
            end
         endcase
      end
      if (st_r.prof == drive_assy_pkg::SPLIT_PROFILE && top_tier) begin
         if (st_r.std && switch_enable) begin
            sel_cmd_net = st_r.nctl;
            sel_ref_net = st_r.nrq;
         end else if (switch_enable) begin
            sel_cmd_net = !logic_input_three;
            sel_ref_net = !logic_input_three;
         end else begin
            sel_cmd_net = 1'b1;
            sel_ref_net = 1'b1;
         end
      end else if (top_tier) begin
         sel_cmd_net = switch_enable ? !logic_input_three : 1'b1;
         sel_ref_net = sel_cmd_net;
      end else begin
         sel_cmd_net = !(logic_input_three || term_run_fwd || term_run_rev);
         sel_ref_net = sel_cmd_net;
      end
      st_nxt.cnet = sel_cmd_net;
      st_nxt.rnet = sel_ref_net;
      if (sel_cmd_net) begin
         if (st_r.std) begin
            st_nxt.cw = 16'h0000;
            st_nxt.cw[drive_assy_pkg::CW_CMD_SW] = st_r.nctl;
            st_nxt.cw[drive_assy_pkg::CW_REF_SW] = st_r.nrq;
            st_nxt.fwd = st_r.nfwd;
            st_nxt.rev = st_r.nrev;
            st_nxt.frst = st_r.nfrst;
         end else begin
            st_nxt.cw = st_r.ncmd;
            st_nxt.fwd = 1'b0;
            st_nxt.rev = 1'b0;
            st_nxt.frst = 1'b0;
         end
      end else begin
         st_nxt.cw = 16'h0000;
         st_nxt.fwd = term_run_fwd;
         st_nxt.rev = term_run_rev;
         st_nxt.frst = 1'b0;
      end
      st_nxt.sp = sel_ref_net ? st_r.nref : analog_input_two;
      // Status assembly on scanner request
      st_nxt.ivld = link.out_valid;
      b0 = 8'h00;
      // Answer data held until the next request
      if (link.out_valid) begin
         unique case (link.in_asm_id)
            drive_assy_pkg::ASM_BASIC_IN: begin
               b0[drive_assy_pkg::B_FAULTED] = st_faulted;
               b0[drive_assy_pkg::B_RUN_F] = st_run_fwd;
               st_nxt.idat = {output_speed_word, 8'h00, b0};
            end
            drive_assy_pkg::ASM_EXT_IN: begin
               b0 = {st_at_ref, st_r.rnet, st_r.cnet, st_ready, st_run_rev,
                  st_run_fwd, st_warning, st_faulted};
               st_nxt.idat = {output_speed_word, drive_state, b0};
            end
            drive_assy_pkg::ASM_NATIVE_IN: begin
               st_nxt.idat = {output_speed_word, native_status_word};
            end
            default: begin
               st_nxt.idat = drive_assy_pkg::ZERO_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.in_data = st_r.idat;
   assign link.in_valid = st_r.ivld;
   assign control_word = st_r.cw;
   assign speed_setpoint_word = st_r.sp;
   assign run_fwd = st_r.fwd;
   assign run_rev = st_r.rev;
   assign fault_reset = st_r.frst;
   assign standard_profile = st_r.std;
   assign cmd_from_net = st_r.cnet;
   assign ref_from_net = st_r.rnet;
   assign profile_active = st_r.prof;
endmodule : drive_end

// >>> testbench/drive_assy_monitor.sv
// Checker of the assembly link between scanner and drive
`timescale 1ns/1ps
module drive_assy_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Link
   input wire logic [7:0] out_asm_id,
   input wire logic [31:0] out_data,
   input wire logic out_valid,
   input wire logic [7:0] in_asm_id,
   input wire logic [31:0] in_data,
   input wire logic in_valid
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   AST_ANSWER_NEXT: assert property (
      out_valid |=> in_valid) else $error("No answer");
   AST_ANSWER_CAUSE: assert property (
      $rose(in_valid) |-> $past(out_valid)) else $error("Stray answer");
   AST_BASIC_OUT_ZERO: assert property (
      out_valid && out_asm_id == drive_assy_pkg::ASM_BASIC_OUT
      |-> (out_data[15:0] & 16'hFFFA) == 16'h0000) else $error("Bad 20");
   AST_EXT_OUT_ZERO: assert property (
      out_valid && out_asm_id == drive_assy_pkg::ASM_EXT_OUT
      |-> (out_data[15:0] & 16'hFF98) == 16'h0000) else $error("Bad 21");
   AST_BASIC_IN_ZERO: assert property (
      in_valid && in_asm_id == drive_assy_pkg::ASM_BASIC_IN
      |-> (in_data[15:0] & 16'hFFFA) == 16'h0000) else $error("Bad 70");
   AST_UNKNOWN_IN_ZERO: assert property (
      in_valid && !(in_asm_id inside {8'h46, 8'h47, 8'h65})
      |-> in_data == 32'h0000_0000) else $error("Bad unknown id");
   AST_OUT_HOLD: assert property (
      !out_valid |-> $stable(out_data)) else $error("Output moved");
   AST_IN_HOLD: assert property (
      !in_valid |-> $stable(in_data)) else $error("Input moved");
endmodule : drive_assy_monitor

// >>> testbench/drive_assembly_channel_select_test.sv
// Self-checking bench joining both link ends
`timescale 1ns/1ps
module drive_assembly_channel_select_test;
   // ------
   // Stimulus
   // ------
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] osel = 8'h14, isel = 8'h46, dst = 8'h00;
   logic send = 1'b0, u_fwd = 1'b0, u_rev = 1'b0, u_fr = 1'b0;
   logic u_ctl = 1'b0, u_ref = 1'b0, pset = 1'b0, swe = 1'b0;
   logic li3 = 1'b0, trf = 1'b0, trr = 1'b0;
   logic pstd = 1'b0, pctl = 1'b0, pref = 1'b0;
   logic [1:0] lvl = 2'h0;
   logic [5:0] stb = 6'h00;
   drive_assy_pkg::profile_e prof = drive_assy_pkg::COMBINED_PROFILE;
   logic [15:0] ncmd = 16'h0000, sref = 16'h0000, ai2 = 16'h0000;
   logic [15:0] nst = 16'h0000, ospd = 16'h0000, cw, sp;
   logic [31:0] sdat, seed = 32'h0000_E8C5;
   logic sval, rf, rr, fr, stdp, cnet, rnet;
   drive_assy_pkg::profile_e pact;
   logic [7:0] oid [3] = '{8'h14, 8'h15, 8'h64};
   logic [7:0] iid [4] = '{8'h46, 8'h47, 8'h65, 8'h00};
   logic [70:0] q [$];
   int miscompares = 0, num_checks = 0;
   always #20 clk_sys = ~clk_sys;
   drive_assy_if drive_assy_if_i ();
   scanner_end scanner_end_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(drive_assy_if_i.scanner), .out_sel(osel), .in_sel(isel),
      .send(send), .run_fwd(u_fwd), .run_rev(u_rev), .fault_reset(u_fr),
      .bus_control_request(u_ctl), .bus_reference_request(u_ref),
      .native_command_word(ncmd), .speed_reference_word(sref),
      .status_data(sdat), .status_valid(sval));
   drive_end drive_end_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .link(drive_assy_if_i.drive), .access_level(lvl), .profile_set(pset),
      .profile_select(prof), .switch_enable(swe), .logic_input_three(li3),
      .term_run_fwd(trf), .term_run_rev(trr), .analog_input_two(ai2),
      .native_status_word(nst), .output_speed_word(ospd),
      .drive_state(dst), .st_faulted(stb[0]), .st_warning(stb[1]),
      .st_run_fwd(stb[2]), .st_run_rev(stb[3]), .st_ready(stb[4]),
      .st_at_ref(stb[5]), .control_word(cw), .speed_setpoint_word(sp),
      .run_fwd(rf), .run_rev(rr), .fault_reset(fr),
      .standard_profile(stdp), .cmd_from_net(cnet), .ref_from_net(rnet),
      .profile_active(pact));
   drive_assy_monitor drive_assy_monitor_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .out_asm_id(drive_assy_if_i.out_asm_id),
      .out_data(drive_assy_if_i.out_data),
      .out_valid(drive_assy_if_i.out_valid),
      .in_asm_id(drive_assy_if_i.in_asm_id),
      .in_data(drive_assy_if_i.in_data), .in_valid(drive_assy_if_i.in_valid));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [1:0] pick(input logic std, input logic ctl,
      input logic rq);
      logic c;
      c = 1'b1;
      if (lvl != drive_assy_pkg::TIER_HIGHEST)
         c = !(li3 | trf | trr);
      else if (swe && (prof == drive_assy_pkg::COMBINED_PROFILE || !std))
         c = !li3;
      if (lvl == drive_assy_pkg::TIER_HIGHEST && swe && std &&
         prof == drive_assy_pkg::SPLIT_PROFILE)
         return {ctl, rq};
      return {c, c};
   endfunction : pick
   function automatic logic [70:0] note();
      logic ext, nat, c, r, pc, pr;
      logic [31:0] s;
      logic [15:0] w;
      logic [2:0] k;
      ext = osel == drive_assy_pkg::ASM_EXT_OUT;
      nat = osel == drive_assy_pkg::ASM_NATIVE_OUT;
      {c, r} = pick(!nat, ext & u_ctl, ext & u_ref);
      // status shows channel in force before this assembly
      {pc, pr} = pick(pstd, pctl, pref);
      w = nat ? ncmd : {2'b00, ext & u_ref, ext & u_ctl, 12'h000};
      k = nat ? 3'b000 : {u_fwd, ext & u_rev, u_fr};
      if (!c) begin
         w = 16'h0000;
         k = {trf, trr, 1'b0};
      end
      case (isel)
         8'h46: s = {ospd, 13'h0000, stb[2], 1'b0, stb[0]};
         8'h47: s = {ospd, dst, stb[5], pr, pc, stb[4:0]};
         8'h65: s = {ospd, nst};
         default: s = 32'h0000_0000;
      endcase
      return {isel == 8'h47, s, w, r ? sref : ai2, k, !nat, c, r};
   endfunction : note
   task automatic check(input logic [70:0] got, input logic [70:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("Checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   // ------
   // Checking
   // ------
   initial begin : watch
      logic [70:0] e;
      forever begin
         @(posedge clk_sys);
         #2;
         if (sval === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : {71{1'b1}};
            check({e[70], sdat, cw, sp, rf, rr, fr, stdp, cnet,
               rnet}, e);
            check({70'h0, pact}, {70'h0, prof});
         end
      end
   end
   initial begin : limit
      repeat (2000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end
   initial begin : main
      logic [31:0] v;
      repeat (5) step();
      rst_n = 1'b1;
      check({69'h0, stdp, pact}, 71'h0);
      for (int n = 0; n < 80; n++) begin
         v = rnd();
         osel = oid[v[1:0] % 3];
         isel = iid[v[3:2]];
         lvl = (v[5:4] == 2'h3) ? 2'h2 : v[5:4];
         prof = drive_assy_pkg::profile_e'(v[6]);
         {swe, li3} = v[8:7];
         trf = v[9] & v[10];
         trr = v[11] & v[12];
         {u_fwd, u_rev, u_fr, u_ctl, u_ref} = v[17:13];
         stb = v[23:18];
         dst = v[31:24];
         v = rnd();
         {ncmd, sref} = v;
         v = rnd();
         {ai2, nst} = v;
         v = rnd();
         ospd = v[15:0];
         pset = 1'b1;
         step();
         pset = 1'b0;
         repeat (2) step();
         send = 1'b1;
         q.push_back(note());
         pstd = osel != drive_assy_pkg::ASM_NATIVE_OUT;
         pctl = (osel == drive_assy_pkg::ASM_EXT_OUT) & u_ctl;
         pref = (osel == drive_assy_pkg::ASM_EXT_OUT) & u_ref;
         step();
         send = 1'b0;
         repeat (5) step();
      end
      if (q.size() != 0)
         miscompares++;
      end_sim();
   end
endmodule : drive_assembly_channel_select_test
